/* File: core/cfifo_top.sv */
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module cfifo_top (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // push side
  input wire logic push_valid,
  input wire cfifo_pkg::cfifo_word_t push_word,
  output logic push_ready,
  // pop side
  input wire logic pop_request,
  input wire logic output_register_reset,
  output logic [63:0] read_data,
  output logic [7:0] read_parity_out,
  output logic pop_empty,
  // flags and interrupt
  output logic near_full_flag,
  output logic near_empty_flag,
  output logic irq
);
  import cfifo_pkg::*;

  // ==========================================================
  // declarations
  cfifo_cfg_t cfg_r;
  logic [12:0] nf_thr_r;
  logic [12:0] ne_thr_r;
  logic [71:0] output_reset_value_r;
  logic [71:0] init_r;
  cfifo_cfg_t cfg_nxt;
  logic [12:0] nf_thr_nxt;
  logic [12:0] ne_thr_nxt;
  logic [71:0] output_reset_value_nxt;
  logic [71:0] init_nxt;
  logic [3:0] irq_mask_nxt;
  logic [3:0] irq_st_r;
  logic [3:0] irq_st_nxt;
  logic [3:0] irq_mask_r;
  logic irq_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic hready_r;
  logic [12:0] wr_ptr_r;
  logic [12:0] rd_ptr_r;
  logic [13:0] mem_cnt_r;
  logic [13:0] mem_cnt_nxt;
  logic la_valid_r;
  logic la_valid_nxt;
  logic empty_r;
  logic empty_nxt;
  logic push_ready_r;
  cfifo_word_t stage_r;
  cfifo_word_t stage_nxt;
  cfifo_word_t out_r;
  cfifo_word_t out_nxt;
  cfifo_word_t mem_word;
  logic nf_rise;
  logic ne_rise;

  // ==========================================================
  // bus decode
  logic addr_ph;
  logic addr_ok;
  logic rd_ph;
  logic [7:0] off;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [13:0] status_cnt;
  logic w_ctrl;
  logic w_nf;
  logic w_ne;
  logic w_mask;
  logic w_srlo;
  logic w_srhi;
  logic w_inlo;
  logic w_inhi;
  logic w_init;
  logic irq_clr;

  assign off = haddr[7:0];
  assign addr_ok = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'h0);
  assign addr_ph = hsel & htrans[1] & hready;
  assign rd_ph = addr_ph & ~hwrite & addr_ok;
  assign irq_clr = rd_ph & (off == OFF_IRQ_ST);
  // write strobes act in the data phase, one cycle after the address phase
  assign w_ctrl = wr_pend_r & (addr_r == OFF_CTRL);
  assign w_nf = wr_pend_r & (addr_r == OFF_NF_THR);
  assign w_ne = wr_pend_r & (addr_r == OFF_NE_THR);
  assign w_mask = wr_pend_r & (addr_r == OFF_IRQ_MASK);
  assign w_srlo = wr_pend_r & (addr_r == OFF_OUTPUT_RESET_VALUE_LO);
  assign w_srhi = wr_pend_r & (addr_r == OFF_OUTPUT_RESET_VALUE_HI);
  assign w_inlo = wr_pend_r & (addr_r == OFF_INIT_LO);
  assign w_inhi = wr_pend_r & (addr_r == OFF_INIT_HI);
  assign w_init = w_inlo | w_inhi;

  // entries reported in the status word include the lookahead head
  assign status_cnt = mem_cnt_r + {13'h0, la_valid_r};

  always_comb begin
    status_word = 32'h0;
    status_word[ST_EMPTY] = empty_r;
    status_word[ST_FULL] = ~push_ready_r;
    status_word[ST_NEAR_FULL] = near_full_flag;
    status_word[ST_NEAR_EMPTY] = near_empty_flag;
    status_word[ST_COUNT_LSB +: 14] = status_cnt;
  end

  assign rd_mux =
    (off == OFF_CTRL) ? {24'h0, cfg_r} :
    (off == OFF_NF_THR) ? {19'h0, nf_thr_r} :
    (off == OFF_NE_THR) ? {19'h0, ne_thr_r} :
    (off == OFF_STATUS) ? status_word :
    (off == OFF_IRQ_ST) ? {28'h0, irq_st_r} :
    (off == OFF_IRQ_MASK) ? {28'h0, irq_mask_r} :
    (off == OFF_OUTPUT_RESET_VALUE_LO) ? output_reset_value_r[31:0] :
    (off == OFF_OUTPUT_RESET_VALUE_HI) ? output_reset_value_r[63:32] :
    (off == OFF_INIT_LO) ? init_r[31:0] :
    (off == OFF_INIT_HI) ? init_r[63:32] : 32'h0;

  // ==========================================================
  // bus registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h0;
      hready_r <= 1'b0;
    end else begin
      wr_pend_r <= addr_ph & hwrite & addr_ok;
      addr_r <= addr_ph ? off : addr_r;
      hrdata_r <= rd_ph ? rd_mux : 32'h0;
      hready_r <= 1'b1;
    end
  end

  // ==========================================================
  // configuration registers
  assign cfg_nxt = w_ctrl ? cfifo_cfg_t'(hwdata[7:0]) : cfg_r;
  assign nf_thr_nxt = w_nf ? hwdata[12:0] : nf_thr_r;
  assign ne_thr_nxt = w_ne ? hwdata[12:0] : ne_thr_r;
  assign irq_mask_nxt = w_mask ? hwdata[3:0] : irq_mask_r;
  assign output_reset_value_nxt = {(w_srhi ? 8'h00 : output_reset_value_r[71:64]),
                      (w_srhi ? hwdata : output_reset_value_r[63:32]),
                      (w_srlo ? hwdata : output_reset_value_r[31:0])};
  assign init_nxt = {(w_inhi ? 8'h00 : init_r[71:64]),
                     (w_inhi ? hwdata : init_r[63:32]),
                     (w_inlo ? hwdata : init_r[31:0])};

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_r <= CTRL_RST;
      nf_thr_r <= THR_RST;
      ne_thr_r <= THR_RST;
      irq_mask_r <= 4'h0;
      output_reset_value_r <= VALUE_RST;
      init_r <= VALUE_RST;
    end else begin
      cfg_r <= cfg_nxt;
      nf_thr_r <= nf_thr_nxt;
      ne_thr_r <= ne_thr_nxt;
      irq_mask_r <= irq_mask_nxt;
      output_reset_value_r <= output_reset_value_nxt;
      init_r <= init_nxt;
    end
  end

  // ==========================================================
  // queue control
  logic la_mode;
  logic flush;
  logic do_push;
  logic mem_rd;
  logic [13:0] cap;
  logic [13:0] entries_nxt;
  logic [13:0] free_nxt;
  logic sr_load;

  function automatic logic [12:0] ptr_inc(input logic [12:0] p, input logic [13:0] c);
    ptr_inc = ({1'b0, p} + 14'h1 == c) ? 13'h0 : p + 13'h1;
  endfunction

  // one clock drives both sides, so common clock needs no crossing
  assign la_mode = cfg_r.lookahead_enable & ~cfg_r.common_clock_select;
  assign flush = w_ctrl;
  assign cap = capacity(cfg_r);
  assign do_push = push_valid & push_ready_r;
  assign mem_rd = (mem_cnt_r != 14'h0) &
                  (la_mode ? (~la_valid_r | pop_request) : pop_request);
  assign mem_cnt_nxt = flush ? 14'h0 :
                       mem_cnt_r + {13'h0, do_push} - {13'h0, mem_rd};
  assign la_valid_nxt = ~flush & la_mode & (mem_rd | (la_valid_r & ~pop_request));
  assign entries_nxt = mem_cnt_nxt + {13'h0, la_valid_nxt};
  // the lookahead head holds one word beyond the memory
  assign free_nxt = cap + {13'h0, la_mode} - entries_nxt;
  assign empty_nxt = la_mode ? ~la_valid_nxt : (mem_cnt_nxt == 14'h0);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_r <= 13'h0;
      rd_ptr_r <= 13'h0;
      mem_cnt_r <= 14'h0;
      la_valid_r <= 1'b0;
      empty_r <= 1'b1;
      push_ready_r <= 1'b0;
    end else begin
      wr_ptr_r <= flush ? 13'h0 : (do_push ? ptr_inc(wr_ptr_r, cap) : wr_ptr_r);
      rd_ptr_r <= flush ? 13'h0 : (mem_rd ? ptr_inc(rd_ptr_r, cap) : rd_ptr_r);
      mem_cnt_r <= mem_cnt_nxt;
      la_valid_r <= la_valid_nxt;
      empty_r <= empty_nxt;
      push_ready_r <= mem_cnt_nxt < cap;
    end
  end

  cfifo_ram u_ram (
    .clock(clock),
    .wr_en(do_push),
    .wr_addr(wr_ptr_r),
    .wr_word(mask_word(push_word, cfg_r)),
    .rd_addr(rd_ptr_r),
    .rd_word(mem_word)
  );

  // ==========================================================
  // output path
  assign sr_load = output_register_reset & cfg_r.pipe_enable &
                   cfg_r.common_clock_select;
  assign stage_nxt = w_init ? map_value(init_nxt, cfg_r) :
                     (mem_rd ? mem_word : stage_r);
  assign out_nxt = sr_load ? map_value(output_reset_value_r, cfg_r) :
                   w_init ? map_value(init_nxt, cfg_r) :
                   cfg_r.pipe_enable ? stage_r : stage_nxt;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage_r <= '0;
      out_r <= '0;
    end else begin
      stage_r <= stage_nxt;
      out_r <= out_nxt;
    end
  end

  // ==========================================================
  // flags
  cfifo_flag u_nf (
    .clock(clock),
    .rstn(rstn),
    .level(free_nxt),
    .thr(nf_thr_r),
    .flag_r(near_full_flag),
    .rise_r(nf_rise)
  );

  cfifo_flag u_ne (
    .clock(clock),
    .rstn(rstn),
    .level(entries_nxt),
    .thr(ne_thr_r),
    .flag_r(near_empty_flag),
    .rise_r(ne_rise)
  );

  // ==========================================================
  // interrupts: set wins over read clear
  logic [3:0] irq_set;
  assign irq_set[IRQ_OVERFLOW] = push_valid & ~push_ready_r;
  assign irq_set[IRQ_UNDERFLOW] = pop_request & empty_r;
  assign irq_set[IRQ_NEAR_FULL] = nf_rise;
  assign irq_set[IRQ_NEAR_EMPTY] = ne_rise;
  assign irq_st_nxt = (irq_st_r & ~{4{irq_clr}}) | irq_set;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_st_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_r <= |(irq_st_nxt & irq_mask_r);
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign push_ready = push_ready_r;
  assign pop_empty = empty_r;
  assign read_data = out_r.data;
  assign read_parity_out = out_r.parity;
  assign irq = irq_r;
endmodule

/* File: core/cfifo_pkg.sv */
package cfifo_pkg;

  // ==========================================================
  // types
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] parity;
  } cfifo_word_t;

  typedef struct packed {
    logic common_clock_select;
    logic pipe_enable;
    logic lookahead_enable;
    logic double_width;
    logic large_variant;
    logic [2:0] width_code;
  } cfifo_cfg_t;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NF_THR = 8'h04;
  localparam logic [7:0] OFF_NE_THR = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_OUTPUT_RESET_VALUE_LO = 8'h18;
  localparam logic [7:0] OFF_OUTPUT_RESET_VALUE_HI = 8'h1C;
  localparam logic [7:0] OFF_INIT_LO = 8'h20;
  localparam logic [7:0] OFF_INIT_HI = 8'h24;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] CTRL_RST = 8'h48;
  localparam logic [12:0] THR_RST = 13'h0004;
  localparam logic [71:0] VALUE_RST = 72'h0;
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_NEAR_FULL = 2;
  localparam int ST_NEAR_EMPTY = 3;
  localparam int ST_COUNT_LSB = 16;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_UNDERFLOW = 1;
  localparam int IRQ_NEAR_FULL = 2;
  localparam int IRQ_NEAR_EMPTY = 3;

  // ==========================================================
  // widths and capacities
  localparam logic [2:0] W4 = 3'h0;
  localparam logic [2:0] W9 = 3'h1;
  localparam logic [2:0] W18 = 3'h2;
  localparam logic [2:0] W36 = 3'h3;
  localparam logic [2:0] W72 = 3'h4;
  localparam logic [13:0] CAP_LARGE = 14'h2000;
  localparam logic [13:0] CAP_SMALL = 14'h1000;

  // effective width after variant and double width
  function automatic logic [2:0] eff_code(input cfifo_cfg_t c);
    logic [2:0] lim;
    lim = c.large_variant ? W36 : W18;
    if (c.double_width) begin
      eff_code = c.large_variant ? W72 : W36;
    end else begin
      eff_code = (c.width_code > lim) ? lim : c.width_code;
    end
  endfunction

  function automatic logic [13:0] capacity(input cfifo_cfg_t c);
    logic [13:0] base;
    base = c.large_variant ? CAP_LARGE : CAP_SMALL;
    capacity = base >> eff_code(c);
  endfunction

  // value bits onto data and parity outputs
  function automatic cfifo_word_t map_value(input logic [71:0] v, input cfifo_cfg_t c);
    cfifo_word_t w;
    w = '0;
    if (c.double_width && !c.large_variant) begin
      w.data = {32'h0, v[33:18], v[15:0]};
      w.parity = {4'h0, v[35:34], v[17:16]};
    end else if (c.double_width) begin
      w.data = {v[67:36], v[31:0]};
      w.parity = {v[71:68], v[35:32]};
    end else begin
      case (eff_code(c))
        W4: w.data = {60'h0, v[3:0]};
        W9: w = '{data: {56'h0, v[7:0]}, parity: {7'h0, v[8]}};
        W18: w = '{data: {48'h0, v[15:0]}, parity: {6'h0, v[17:16]}};
        default: w = '{data: {32'h0, v[31:0]}, parity: {4'h0, v[35:32]}};
      endcase
    end
    map_value = w;
  endfunction

  // clears bits above the selected width
  function automatic cfifo_word_t mask_word(input cfifo_word_t x, input cfifo_cfg_t c);
    cfifo_word_t m;
    case (eff_code(c))
      W4: m = '{data: 64'h0000_0000_0000_000F, parity: 8'h00};
      W9: m = '{data: 64'h0000_0000_0000_00FF, parity: 8'h01};
      W18: m = '{data: 64'h0000_0000_0000_FFFF, parity: 8'h03};
      W36: m = '{data: 64'h0000_0000_FFFF_FFFF, parity: 8'h0F};
      default: m = '{data: 64'hFFFF_FFFF_FFFF_FFFF, parity: 8'hFF};
    endcase
    mask_word = x & m;
  endfunction

endpackage

/* File: core/cfifo_ram.sv */
`timescale 1ns/1ps
module cfifo_ram (
  // clock
  input wire logic clock,
  // write port
  input wire logic wr_en,
  input wire logic [12:0] wr_addr,
  input wire cfifo_pkg::cfifo_word_t wr_word,
  // read port
  input wire logic [12:0] rd_addr,
  output cfifo_pkg::cfifo_word_t rd_word
);
  import cfifo_pkg::*;

  // ==========================================================
  // storage
  cfifo_word_t mem [0:8191];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_word;
    end
  end

  assign rd_word = mem[rd_addr];
endmodule

/* File: core/cfifo_flag.sv */
`timescale 1ns/1ps
module cfifo_flag (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // level and threshold
  input wire logic [13:0] level,
  input wire logic [12:0] thr,
  // flag and its rising event
  output logic flag_r,
  output logic rise_r
);
  // ==========================================================
  // hysteresis: set at or below, clear above threshold plus one
  logic set_c;
  logic clr_c;
  assign set_c = level <= {1'b0, thr};
  assign clr_c = level > ({1'b0, thr} + 14'h1);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      flag_r <= set_c ? 1'b1 : (clr_c ? 1'b0 : flag_r);
      rise_r <= set_c & ~flag_r;
    end
  end
endmodule

/* File: sim/cfifo_top_asserts.sv */
`timescale 1ns/1ps
module cfifo_top_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // queue status
  input wire logic push_ready,
  input wire logic pop_empty,
  input wire logic near_full_flag,
  input wire logic near_empty_flag
);
  // ==========================================================
  // helpers
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire bad_addr = haddr[31:8] != 24'h0 || haddr[1:0] != 2'h0;
  logic rd_r;
  always_ff @(posedge clock) begin
    rd_r <= rd_take;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // properties
  sequence s_bad_read;
    rd_take && bad_addr ##1 1'b1;
  endsequence
  sequence s_idle_empty;
    pop_empty [*3];
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_ready;
    $past(rstn) |-> hreadyout;
  endproperty
  property p_idle_zero;
    !rd_r |-> hrdata == 32'h0;
  endproperty
  property p_unmapped;
    s_bad_read |-> hrdata == 32'h0;
  endproperty
  property p_empty_ready;
    pop_empty && $past(rstn, 2) |-> push_ready;
  endproperty
  property p_full_near;
    $fell(push_ready) |-> ##[0:2] near_full_flag;
  endproperty
  property p_drain_near;
    $rose(pop_empty) |-> ##[0:2] near_empty_flag;
  endproperty
  property p_empty_near;
    s_idle_empty |-> near_empty_flag;
  endproperty
  a_okay: assert property (p_okay) else $error("bus error response");
  a_ready: assert property (p_ready) else $error("bus not ready");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_empty_ready: assert property (p_empty_ready) else $error("empty but refusing");
  a_full_near: assert property (p_full_near) else $error("full without near full");
  a_drain_near: assert property (p_drain_near) else $error("drained, no near empty");
  a_empty_near: assert property (p_empty_near) else $error("empty, no near empty");
endmodule

/* File: sim/cfifo_user.sv */
`timescale 1ns/1ps
module cfifo_user (
  // clock
  input wire logic clock,
  // budgets
  input wire logic ld,
  input wire logic [15:0] push_n,
  input wire logic [15:0] pop_n,
  input wire logic slow,
  // queue side
  input wire logic push_ready,
  input wire logic pop_empty,
  output logic push_valid,
  output cfifo_pkg::cfifo_word_t push_word,
  output logic pop_request
);
  import cfifo_pkg::*;
  int pu = 0;
  int po = 0;
  initial begin
    push_valid = 1'b0;
    push_word = '0;
    pop_request = 1'b0;
  end
  // ==========================================================
  // pacing, word held until taken
  always @(posedge clock) begin
    if (push_valid && push_ready) pu = pu - 1;
    if (pop_request && !pop_empty) po = po - 1;
    if (ld) begin
      pu = push_n;
      po = pop_n;
    end
    if (!push_valid || push_ready || pu == 0) begin
      push_valid <= pu > 0 && !(slow && $urandom_range(1) == 0);
      push_word <= {$urandom, $urandom, 8'($urandom)};
    end
    pop_request <= po > 0 && !(slow && $urandom_range(1) == 0);
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cfifo_pkg::*;
  // ==========================================================
  // signals
  localparam int CAP = 8192 >> 4;
  localparam int NFT = 5;
  localparam int NET = 3;
  logic clock = 0, rstn = 0, hsel = 0, hwrite = 0, out_rst = 0, ld = 0, slow = 0;
  logic track = 0, pipe = 0, nf_m = 0, ne_m = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] push_n = 0, pop_n = 0;
  logic hreadyout, hresp, push_valid, push_ready, pop_request, pop_empty, nf, ne, irq;
  logic [63:0] read_data;
  logic [7:0] read_parity_out;
  logic [1:0] pv = 2'b00;
  logic [71:0] v;
  cfifo_word_t push_word;
  cfifo_word_t pw [2];
  cfifo_word_t mq [$];
  int error_cnt = 0, check_count = 0;
  logic [7:0] cfg [6] = '{8'h48, 8'h41, 8'h42, 8'h4B, 8'h50, 8'h58};
  int steps [7][2] = '{'{CAP, 0}, '{0, 6}, '{0, 1}, '{0, 501}, '{0, 1}, '{1, 0}, '{1, 0}};
  always #20 clock = ~clock;
  cfifo_top dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .push_valid(push_valid), .push_word(push_word),
    .push_ready(push_ready), .pop_request(pop_request), .output_register_reset(out_rst),
    .read_data(read_data), .read_parity_out(read_parity_out), .pop_empty(pop_empty),
    .near_full_flag(nf), .near_empty_flag(ne), .irq(irq));
  cfifo_user u_usr (.clock(clock), .ld(ld), .push_n(push_n), .pop_n(pop_n), .slow(slow),
    .push_ready(push_ready), .pop_empty(pop_empty), .push_valid(push_valid),
    .push_word(push_word), .pop_request(pop_request));
  // ==========================================================
  // tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic setcfg(input logic [7:0] c);
    bus(32'(OFF_CTRL), 1'b1, {24'h0, c});
    mq.delete();
  endtask
  task automatic run(input int pu, input int po, input int n);
    push_n <= 16'(pu);
    pop_n <= 16'(po);
    ld <= 1'b1;
    @(posedge clock);
    ld <= 1'b0;
    @(posedge clock);
    while (n == 0 && (u_usr.pu != 0 || u_usr.po != 0)) @(posedge clock);
    repeat (n + 4) @(posedge clock);
  endtask
  task automatic flags();
    if (CAP - mq.size() <= NFT) nf_m = 1'b1;
    else if (CAP - mq.size() > NFT + 1) nf_m = 1'b0;
    if (mq.size() <= NET) ne_m = 1'b1;
    else if (mq.size() > NET + 1) ne_m = 1'b0;
    chk_reg({30'h0, nf, ne}, {30'h0, nf_m, ne_m});
    bus(32'(OFF_STATUS), 1'b0, 32'h0);
    chk_reg({18'h0, rd[29:16]}, 32'(mq.size()));
  endtask
  function automatic logic [71:0] expmap(input logic [7:0] c, input logic [71:0] v);
    if (c[4] && !c[3]) return {32'h0, v[33:18], v[15:0], 4'h0, v[35:34], v[17:16]};
    if (c[4]) return {v[67:36], v[31:0], v[71:68], v[35:32]};
    case (c[2:0])
      3'h0: return {60'h0, v[3:0], 8'h0};
      3'h1: return {56'h0, v[7:0], 7'h0, v[8]};
      3'h2: return {48'h0, v[15:0], 6'h0, v[17:16]};
      default: return {32'h0, v[31:0], 4'h0, v[35:32]};
    endcase
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // reference queue, compared at every pop result while track is set
  always @(posedge clock) begin
    if (track && pv[pipe] === 1'b1) chk_out({read_data, read_parity_out}, pw[pipe]);
    pw[1] = pw[0];
    pv = {pv[0], 1'b0};
    if (!rstn) mq.delete();
    else begin
      if (push_valid && push_ready) mq.push_back(push_word);
      if (pop_request && !pop_empty && mq.size() > 0) begin
        pv[0] = 1'b1;
        pw[0] = mq.pop_front();
      end
    end
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h8D4F));
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    bus(32'(OFF_CTRL), 1'b0, 32'h0);
    chk_reg(rd, {24'h0, CTRL_RST});
    bus(32'(OFF_NF_THR), 1'b0, 32'h0);
    chk_reg(rd, {19'h0, THR_RST});
    bus(32'h100, 1'b0, 32'h0);
    chk_reg(rd, 32'h0);
    foreach (cfg[i]) begin
      setcfg(cfg[i]);
      v = {8'h0, $urandom, $urandom};
      bus(32'(OFF_INIT_LO), 1'b1, v[31:0]);
      bus(32'(OFF_INIT_HI), 1'b1, v[63:32]);
      repeat (2) @(posedge clock);
      chk_out({read_data, read_parity_out}, expmap(cfg[i], v));
    end
    for (int p = 0; p < 2; p++) begin
      setcfg(8'h98 | 8'(p << 6));
      bus(32'(OFF_INIT_LO), 1'b1, 32'h0);
      bus(32'(OFF_INIT_HI), 1'b1, 32'h0);
      v = {8'h0, $urandom, $urandom};
      bus(32'(OFF_OUTPUT_RESET_VALUE_LO), 1'b1, v[31:0]);
      bus(32'(OFF_OUTPUT_RESET_VALUE_HI), 1'b1, v[63:32]);
      out_rst <= 1'b1;
      @(posedge clock);
      out_rst <= 1'b0;
      @(posedge clock);
      chk_out({read_data, read_parity_out}, p ? expmap(8'h98, v) : 72'h0);
      pipe <= p[0];
      track <= 1'b1;
      slow <= 1'b1;
      run(40, 40, 0);
      track <= 1'b0;
    end
    setcfg(8'h98);
    slow <= 1'b0;
    bus(32'(OFF_NF_THR), 1'b1, NFT);
    bus(32'(OFF_NE_THR), 1'b1, NET);
    foreach (steps[i]) begin
      run(steps[i][0], steps[i][1], 0);
      flags();
    end
    bus(32'(OFF_IRQ_MASK), 1'b1, 32'h0);
    bus(32'(OFF_IRQ_ST), 1'b0, 32'h0);
    run(0, 8, 12);
    run(0, 0, 0);
    chk_reg({31'h0, irq}, 32'h0);
    bus(32'(OFF_IRQ_MASK), 1'b1, 32'h1 << IRQ_UNDERFLOW);
    repeat (2) @(posedge clock);
    chk_reg({31'h0, irq}, 32'h1);
    bus(32'(OFF_IRQ_ST), 1'b0, 32'h0);
    chk_reg({31'h0, rd[IRQ_UNDERFLOW]}, 32'h1);
    repeat (2) @(posedge clock);
    chk_reg({31'h0, irq}, 32'h0);
    setcfg(8'h78);
    run(1, 0, 0);
    chk_reg({31'h0, pop_empty}, 32'h0);
    chk_out({read_data, read_parity_out}, mq[0]);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
endmodule
bind cfifo_top cfifo_top_asserts u_chk (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .push_ready(push_ready), .pop_empty(pop_empty),
  .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag));
